// File: hw/drive_cmd_pkg.sv
/*
 * constants for the drive command/status word interpreter: register map,
 * field positions, reset values, source and profile encodings.
 * assumes a 32-bit apb register bus with word-aligned registers.
 */
package drive_cmd_pkg;
   // register byte offsets
   localparam logic [7:0] off_cmd_terminal = 8'h00;
   localparam logic [7:0] off_cmd_display = 8'h04;
   localparam logic [7:0] off_cmd_modbus = 8'h08;
   localparam logic [7:0] off_cmd_canopen = 8'h0c;
   localparam logic [7:0] off_cmd_fieldbus = 8'h10;
   localparam logic [7:0] off_cmd_ethernet = 8'h14;
   localparam logic [7:0] off_config = 8'h18;
   localparam logic [7:0] off_reference = 8'h1c;
   localparam logic [7:0] off_speed_limits = 8'h20;
   localparam logic [7:0] off_drive_inputs = 8'h24;
   localparam logic [7:0] off_drive_command_word = 8'h28;
   localparam logic [7:0] off_drive_state_word = 8'h2c;
   localparam logic [7:0] off_pre_ramp_reference = 8'h30;
   localparam logic [7:0] off_run_status = 8'h34;
   // config register fields
   localparam int cfg_cmd_src_lsb = 0;
   localparam int cfg_ref_src_lsb = 4;
   localparam int cfg_profile_bit = 8;
   localparam int cfg_wire_bit = 9;
   localparam int cfg_stop_type_lsb = 12;
   localparam logic [15:0] config_reset = 16'h0000;
   // drive inputs register fields (plant state fed in by software)
   localparam int in_supply_bit = 0;
   localparam int in_power_only_bit = 1;
   localparam int in_fault_bit = 2;
   localparam int in_warning_bit = 3;
   localparam int in_stop_key_bit = 4;
   localparam int in_reverse_bit = 5;
   localparam int in_speed_mode_bit = 6;
   localparam int in_ref_reached_bit = 7;
   // command word bits, device-state profile
   localparam int cw_switch_on = 0;
   localparam int cw_enable_voltage = 1;
   localparam int cw_quick_stop_n = 2;
   localparam int cw_enable_op = 3;
   localparam int cw_fault_reset = 7;
   localparam int cw_halt = 8;
   localparam logic [15:0] cw_assignable_mask = 16'hf800;
   // command word bits, io profile
   localparam int cmd_bit_zero = 0;
   localparam int cmd_bit_one = 1;
   // state word bits
   localparam int sw_ready = 0;
   localparam int sw_switched_on = 1;
   localparam int sw_op_enabled = 2;
   localparam int sw_fault = 3;
   localparam int sw_voltage = 4;
   localparam int sw_quick_stop = 5;
   localparam int sw_sw_on_disabled = 6;
   localparam int sw_warning = 7;
   localparam int sw_remote = 9;
   localparam int sw_ref_reached = 10;
   localparam int sw_limit = 11;
   localparam int sw_stop_key = 14;
   localparam int sw_direction = 15;
   // reference in 0.1 hz units, signed, limit 599.0 hz
   localparam logic signed [15:0] ref_max_dhz = 16'sh1766;
   localparam logic signed [15:0] ref_reset = 16'sh0000;
   localparam logic [31:0] limits_reset = 32'h0000_0000;
   localparam logic [15:0] word_reset = 16'h0000;

   // command and reference channels
   typedef enum logic [2:0] {
      src_terminal_block = 3'h0,
      src_display_terminal = 3'h1,
      src_modbus = 3'h2,
      src_canopen = 3'h3,
      src_fieldbus_module = 3'h4,
      src_embedded_ethernet = 3'h5
   } channel_t;
endpackage : drive_cmd_pkg

// File: hw/drive_control_status_words.sv
/*
 * drive command/status word interpreter: selects the active channel's
 * command word, decodes it under the device-state or io profile, runs
 * the device state machine and builds the 16-bit state word.
 * assumes an apb master on sys_clk_in and plant status written by
 * software into the drive inputs register.
 */
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps

// Functional notes
// [R1] one selected channel drives command and reference
// [R2] bit 0 set means switch on
// [R3] bit 1 clear disables voltage, bit 2 quick-stops
// [R4] bit 3 set enables operation
// [R5] fault reset on bit 7 rising edge
// [R6] bit 8 halts yet stays operation enabled
// [R7] two-wire: bit 0 is forward level
// [R8] two-wire bit 0 obeyed on active channel
// [R9] three-wire: bit 0 authorises running
// [R10] three-wire: bit 1 rising edge runs forward
// [R11] three-wire bits obeyed on active channel
// [R12] read-only pre-ramp reference, clamped, resets zero
// [R13] state bits 0..2: ready, on, enabled
// [R14] state bit 3 shows fault
// [R15] state bit 4 supply, forced by power-only
// [R16] state bit 5 quick stop, 6 disabled
// [R17] state bit 7 shows any warning
// [R18] state bit 9 shows network source
// [R19] state bit 10 shows reference reached
// [R20] state bit 11 shows reference outside limits; here only while the speed-mode input is set
// [R21] state bit 14 shows stop key stop
// [R22] state bit 15 shows reverse rotation
// [R23] reserved state bits zero, reserved commands ignored
module drive_control_status_words
   import drive_cmd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // drive commands to motor control
   output logic run_out,
   output logic forward_out,
   output logic halt_out,
   output logic quick_stop_out,
   output logic fault_reset_out,
   output logic [1:0] stop_type_out,
   output logic [15:0] assignable_out,
   output logic [15:0] state_word_out
);

   ////////////////////////////////////////////////////////////////////////
   // state

   // device-state profile states
   // quick stop is its own state so the stop ramp can be told apart
   // from a plain disable; leaving it always passes through disabled
   // so a fresh switch-on sequence is needed to run again
   typedef enum logic [2:0] {
      st_disabled, st_ready, st_switched_on, st_op_enabled,
      st_quick_stop, st_fault
   } dev_state_t;

   logic [15:0] cmd_word_q [6]; // one command word per channel
   logic [15:0] config_q; // source selects, profile, stop type
   logic signed [15:0] ref_q; // requested reference, 0.1 hz units
   logic [31:0] limits_q; // high limit [31:16], low limit [15:0]
   logic [7:0] inputs_q; // plant conditions from software
   dev_state_t state_q, state_d; // device state machine
   logic fault_bit_q; // previous fault-reset bit, for edge detect
   logic fwd_bit_q; // previous 3-wire forward bit
   logic latch_q; // 3-wire run latch
   logic [15:0] eff_cmd_q; // last active channel word
   logic signed [15:0] pre_ramp_q; // clamped reference, read-only
   logic [15:0] status_q; // registered state word

   ////////////////////////////////////////////////////////////////////////
   // decode

   // register selects and field views
   wire channel_t cmd_src = channel_t'(config_q[cfg_cmd_src_lsb +: 3]);
   wire channel_t ref_src = channel_t'(config_q[cfg_ref_src_lsb +: 3]);
   wire io_profile = config_q[cfg_profile_bit];
   wire three_wire = config_q[cfg_wire_bit];
   wire apb_write = psel_in & penable_in & pwrite_in;
   wire cmd_area = (paddr_in < off_config) & (paddr_in[1:0] == 2'b00);
   wire [2:0] cmd_index = paddr_in[4:2];
   // only the selected channel's word reaches the decoder
   wire [15:0] cmd_word =
      cmd_word_q[cmd_src]; // [R1] [R8] [R11]
   wire signed [15:0] high_lim = limits_q[31:16];
   wire signed [15:0] low_lim = limits_q[15:0];

   // device-state profile bits; reserved 4..6, 9, 10 never read
   wire c_switch = cmd_word[cw_switch_on]; // [R2]
   wire c_voltage = cmd_word[cw_enable_voltage]; // [R3]
   wire c_qstop = ~cmd_word[cw_quick_stop_n]; // [R3]
   wire c_enable = cmd_word[cw_enable_op]; // [R4]
   wire c_halt = cmd_word[cw_halt]; // [R6] [R23]
   wire fault_edge =
      cmd_word[cw_fault_reset] & ~fault_bit_q; // [R5]

   // io profile: two-wire level forward, three-wire edge forward
   wire run_auth = cmd_word[cmd_bit_zero]; // [R9]
   wire fwd_edge =
      cmd_word[cmd_bit_one] & ~fwd_bit_q; // [R10]
   wire latch_d = run_auth & (latch_q | fwd_edge); // [R9] [R10]
   wire io_run = three_wire ? latch_d :
      cmd_word[cmd_bit_zero]; // [R7]

   // reference clamp to +/- 599.0 hz
   wire signed [15:0] ref_clamped =
      (ref_q > ref_max_dhz) ? ref_max_dhz :
      (ref_q < -ref_max_dhz) ? -ref_max_dhz : ref_q; // [R12]
   wire out_of_limits = (ref_q > high_lim) |
      (ref_q < low_lim); // [R20]

   ////////////////////////////////////////////////////////////////////////
   // device state machine

   // next state from active command word and fault input
   // the fault input overrides every command, so a stuck fault keeps
   // the drive parked even while the fault-reset bit toggles
   // in the io profile the state only mirrors the run decision; the
   // switch-on sequence bits have no meaning there
   always_comb begin
      state_d = state_q;
      case (state_q)
         st_disabled: begin
            if (c_voltage & ~c_qstop & ~c_switch) begin
               state_d = st_ready;
            end
         end
         st_ready: begin
            if (~c_voltage | c_qstop) begin
               state_d = st_disabled; // [R3]
            end else if (c_switch) begin
               state_d = st_switched_on; // [R2]
            end
         end
         st_switched_on: begin
            if (~c_voltage | c_qstop) begin
               state_d = st_disabled; // [R3]
            end else if (~c_switch) begin
               state_d = st_ready;
            end else if (c_enable) begin
               state_d = st_op_enabled; // [R4]
            end
         end
         st_op_enabled: begin
            // halt keeps this state; the stop happens by ramp type
            if (~c_voltage) begin
               state_d = st_disabled; // [R3]
            end else if (c_qstop) begin
               state_d = st_quick_stop; // [R3]
            end else if (~c_switch) begin
               state_d = st_ready;
            end else if (~c_enable) begin
               state_d = st_switched_on;
            end
         end
         st_quick_stop: begin
            if (~c_voltage | ~c_qstop) begin
               state_d = st_disabled;
            end
         end
         st_fault: begin
            // level on bit 7 does nothing, only the edge clears
            if (fault_edge & ~inputs_q[in_fault_bit]) begin
               state_d = st_disabled; // [R5]
            end
         end
         default: begin
            state_d = st_disabled;
         end
      endcase
      if (inputs_q[in_fault_bit]) begin
         state_d = st_fault;
      end
      if (io_profile) begin
         state_d = inputs_q[in_fault_bit] ? st_fault :
            (io_run ? st_op_enabled : st_switched_on);
      end
   end

   // state word assembly; reserved bits 8, 12, 13 stay zero
   // quick stop bit is active low: it reads 1 while no quick stop runs
   // remote bit looks at the command source only; a network reference
   // with terminal commands still reads as local here
   logic [15:0] status_d;
   always_comb begin
      status_d = word_reset; // [R23]
      status_d[sw_ready] = (state_q != st_disabled) &
         (state_q != st_fault); // [R13]
      status_d[sw_switched_on] = (state_q == st_switched_on) |
         (state_q == st_op_enabled); // [R13]
      status_d[sw_op_enabled] = (state_q == st_op_enabled); // [R13]
      status_d[sw_fault] = (state_q == st_fault); // [R14]
      status_d[sw_voltage] = inputs_q[in_supply_bit] |
         inputs_q[in_power_only_bit]; // [R15]
      status_d[sw_quick_stop] = (state_q != st_quick_stop); // [R16]
      status_d[sw_sw_on_disabled] = (state_q == st_disabled); // [R16]
      status_d[sw_warning] = inputs_q[in_warning_bit]; // [R17]
      status_d[sw_remote] = (cmd_src != src_terminal_block) &
         (cmd_src != src_display_terminal); // [R18]
      status_d[sw_ref_reached] = inputs_q[in_ref_reached_bit]; // [R19]
      status_d[sw_limit] = inputs_q[in_speed_mode_bit] &
         out_of_limits; // [R20]
      status_d[sw_stop_key] = inputs_q[in_stop_key_bit]; // [R21]
      status_d[sw_direction] = inputs_q[in_reverse_bit]; // [R22]
   end

   ////////////////////////////////////////////////////////////////////////
   // registers written by software

   // apb writes; every access completes in its first access cycle
   // writes to read-only or unmapped offsets are dropped silently;
   // the error response comes from the answer process below
   // plant inputs are software-written, so no pin synchroniser is
   // needed: they already live on this clock
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < 6; i++) begin
            cmd_word_q[i] <= word_reset;
         end
         config_q <= config_reset;
         ref_q <= ref_reset;
         limits_q <= limits_reset;
         inputs_q <= 8'h00;
      end else if (apb_write) begin
         if (cmd_area) begin
            cmd_word_q[cmd_index] <= pwdata_in[15:0];
         end
         if (paddr_in == off_config) begin
            config_q <= pwdata_in[15:0];
         end
         if (paddr_in == off_reference) begin
            ref_q <= pwdata_in[15:0];
         end
         if (paddr_in == off_speed_limits) begin
            limits_q <= pwdata_in;
         end
         if (paddr_in == off_drive_inputs) begin
            inputs_q <= pwdata_in[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command state and edge history

   // edge history follows the active word so a channel swap can
   // itself produce an edge; that matches a fresh channel taking over
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= st_disabled;
         fault_bit_q <= 1'b0;
         fwd_bit_q <= 1'b0;
         latch_q <= 1'b0;
         eff_cmd_q <= word_reset;
      end else begin
         state_q <= state_d;
         fault_bit_q <= cmd_word[cw_fault_reset]; // [R5]
         fwd_bit_q <= cmd_word[cmd_bit_one]; // [R10]
         latch_q <= io_profile & three_wire & latch_d; // [R9]
         eff_cmd_q <= cmd_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // the one reference register passes only while the reference source selects a defined channel
   wire ref_valid = (ref_src <= src_embedded_ethernet); // [R1]

   // registered drive commands and status
   // all outputs come from flip-flops, one edge after the decode, so
   // the motor side never sees a glitch from a half-written word
   // run uses the next state so it agrees with the state word that
   // appears one edge later
   // halt only gates run in the device-state profile; the io profile
   // has no halt bit of its own
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_out <= 1'b0;
         forward_out <= 1'b0;
         halt_out <= 1'b0;
         quick_stop_out <= 1'b0;
         fault_reset_out <= 1'b0;
         stop_type_out <= 2'h0;
         assignable_out <= word_reset;
         state_word_out <= word_reset;
         status_q <= word_reset;
         pre_ramp_q <= ref_reset;
      end else begin
         run_out <= (state_d == st_op_enabled) &
            (io_profile | ~c_halt); // [R6]
         forward_out <= io_profile & io_run; // [R7] [R10]
         halt_out <= ~io_profile & c_halt &
            (state_d == st_op_enabled); // [R6]
         quick_stop_out <= (state_d == st_quick_stop); // [R3]
         fault_reset_out <= ~io_profile & fault_edge; // [R5]
         stop_type_out <= config_q[cfg_stop_type_lsb +: 2];
         // freely assignable bits depend on the profile and wiring
         assignable_out <= io_profile ?
            (three_wire ? (cmd_word & 16'hfffc) :
             (cmd_word & 16'hfffe)) :
            (cmd_word & cw_assignable_mask); // [R5] [R7] [R10]
         state_word_out <= status_d;
         status_q <= status_d;
         pre_ramp_q <= ref_valid ? ref_clamped : ref_reset; // [R12]
      end
   end

   // read mux
   // reads return zero in unused upper bits except the pre-ramp reference,
   // which is sign-extended so software sees a plain signed word
   // the run status word exposes the three-wire latch for debug only
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (cmd_area) begin
         rdata_d = {16'h0000, cmd_word_q[cmd_index]};
      end
      case (paddr_in)
         off_config: rdata_d = {16'h0000, config_q};
         off_reference: rdata_d = {16'h0000, ref_q};
         off_speed_limits: rdata_d = limits_q;
         off_drive_inputs: rdata_d = {24'h000000, inputs_q};
         off_drive_command_word: rdata_d = {16'h0000, eff_cmd_q};
         off_drive_state_word: rdata_d = {16'h0000, status_q};
         off_pre_ramp_reference: rdata_d = {{16{pre_ramp_q[15]}},
            pre_ramp_q};
         off_run_status: rdata_d = {29'h0, latch_q, run_out, forward_out};
         default: ;
      endcase
   end

   wire mapped = cmd_area | ((paddr_in >= off_config) &
      (paddr_in <= off_run_status) & (paddr_in[1:0] == 2'b00));
   wire setup = psel_in & ~penable_in;

   // apb answer: ready registered in the setup cycle
   // no wait states: read data is latched from the setup-cycle address
   // and stands exactly one cycle, together with ready
   // a master that drops penable early still gets one ready pulse,
   // which it must ignore
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         pready_out <= setup;
         pslverr_out <= setup & ~mapped;
         prdata_out <= setup ? rdata_d : 32'h0000_0000;
      end
   end

endmodule : drive_control_status_words

// File: bench/drive_words_props.sv
/*
 * port checker for the drive command/status word interpreter.
 * assumes it is bound into drive_control_status_words, one clock.
 */
`timescale 1ns/100ps
module drive_words_props
   import drive_cmd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // apb handshake
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic pready_out,
   // drive side
   input wire logic run_out,
   input wire logic halt_out,
   input wire logic quick_stop_out,
   input wire logic fault_reset_out,
   input wire logic [1:0] stop_type_out,
   input wire logic [15:0] assignable_out,
   input wire logic [15:0] state_word_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   ////////////////////////////////////////////////////////////////////////
   // write history: decoded outputs may move one or two edges after
   logic wr1_q;
   logic wr2_q;
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr1_q <= 1'b0;
         wr2_q <= 1'b0;
      end else begin
         wr1_q <= psel_in && penable_in && pwrite_in;
         wr2_q <= wr1_q;
      end
   end
   // setup cycle, then a single ready cycle
   sequence apb_setup;
      psel_in && !penable_in;
   endsequence
   sequence apb_answer;
      pready_out ##1 !pready_out;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_ready_after_setup: assert property (apb_setup |=> apb_answer)
      else $error("ready missing after setup");
   chk_run_enabled: assert property (
      run_out |=> state_word_out[sw_op_enabled])
      else $error("run without enabled state");
   chk_halt_no_run: assert property (halt_out |-> !run_out)
      else $error("halt while running");
   chk_stop_type_write: assert property (
      $changed(stop_type_out) |-> wr1_q || wr2_q)
      else $error("stop type moved without write");
   chk_fault_pulse: assert property (
      fault_reset_out |=> !fault_reset_out)
      else $error("fault reset longer than a pulse");
   chk_quick_stop_bit: assert property (
      quick_stop_out |=> !state_word_out[sw_quick_stop])
      else $error("quick stop not shown");
   chk_fault_state: assert property (
      state_word_out[sw_fault] |-> state_word_out[2:0] == 3'h0)
      else $error("fault with live state");
   chk_enabled_bits: assert property (
      state_word_out[sw_op_enabled] |->
      state_word_out[sw_switched_on] && state_word_out[sw_ready])
      else $error("enabled without switched on");
   chk_reserved_zero: assert property (
      !state_word_out[8] && state_word_out[13:12] == 2'h0)
      else $error("reserved state bit set");
   chk_fwd_bit_kept: assert property (!assignable_out[0])
      else $error("bit zero left assignable");
endmodule : drive_words_props

bind drive_control_status_words drive_words_props drive_words_props_inst (
   .sys_clk_in(sys_clk_in),
   .resetn_in(resetn_in),
   .psel_in(psel_in),
   .penable_in(penable_in),
   .pwrite_in(pwrite_in),
   .pready_out(pready_out),
   .run_out(run_out),
   .halt_out(halt_out),
   .quick_stop_out(quick_stop_out),
   .fault_reset_out(fault_reset_out),
   .stop_type_out(stop_type_out),
   .assignable_out(assignable_out),
   .state_word_out(state_word_out)
);

// File: bench/drive_fieldbus_master.sv
/*
 * fieldbus master model: writes command words and reads status over apb.
 * assumes one caller at a time and a slave on the same clock.
 */
`timescale 1ns/100ps
module drive_fieldbus_master (
   // clock
   input wire logic sys_clk_in,
   // apb request
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [7:0] paddr_out,
   output logic [31:0] pwdata_out,
   // apb answer
   input wire logic [31:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in
);
   // bus idle from time zero
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h0;
   end
   // request held until ready is seen at an edge; the bench watchdog
   // is the only limit on the wait
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge sys_clk_in);
      psel_out <= 1'b1;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge sys_clk_in);
      penable_out <= 1'b1;
      do begin
         @(posedge sys_clk_in);
      end while (pready_in !== 1'b1);
      r = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
   endtask : xfer
endmodule : drive_fieldbus_master

// File: bench/drive_control_status_words_tb_top.sv
/*
 * self-checking bench for the drive word interpreter.
 * assumes the fieldbus master model and the bound port checker.
 */
`timescale 1ns/100ps
module drive_control_status_words_tb_top
   import drive_cmd_pkg::*;
;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic run, fwd, halt, qstop, frst;
   logic [1:0] stop_type;
   logic [15:0] assignable, state_word;
   int mismatches = 0;
   int checked = 0;
   int pulses = 0;
   // plant inputs and the state bit each one shows up in
   logic [7:0] st_in [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'hc0};
   int st_bit [6] = '{4, 4, 7, 14, 15, 10};
   always #20 sys_clk_in = ~sys_clk_in;
   // count fault reset pulses at the clock
   always @(posedge sys_clk_in) if (frst === 1'b1) pulses++;
   ////////////////////////////////////////////////////////////////////////
   drive_fieldbus_master drive_fieldbus_master_inst (.sys_clk_in(sys_clk_in),
      .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
      .pready_in(pready), .pslverr_in(pslverr));
   drive_control_status_words drive_control_status_words_inst (
      .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .run_out(run), .forward_out(fwd),
      .halt_out(halt), .quick_stop_out(qstop), .fault_reset_out(frst),
      .stop_type_out(stop_type), .assignable_out(assignable),
      .state_word_out(state_word));
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task end_sim;
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // write, then let decode and state word settle (two edges, one spare)
   task wr(input logic [7:0] a, input logic [31:0] d);
      drive_fieldbus_master_inst.xfer(1'b1, a, d, r, e);
      repeat (3) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x);
      drive_fieldbus_master_inst.xfer(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(off_drive_state_word, 32'h60);
      rd(off_pre_ramp_reference, 32'h0);
      rd(8'h3c, 32'h0);
      chk(e, 1'b1);
      wr(off_drive_state_word, 32'hffff);
      rd(off_drive_state_word, 32'h60);
   endtask : t_reset
   // device-state walk: ready, on, enabled, halt, quick stop, fault
   task t_state;
      int p;
      p = pulses;
      wr(off_drive_inputs, 32'h01);
      wr(off_cmd_terminal, 32'h06);
      chk(state_word & 16'h7f, 32'h31);
      wr(off_cmd_terminal, 32'h07);
      chk(state_word & 16'h7f, 32'h33);
      wr(off_cmd_terminal, 32'h0f);
      chk(state_word & 16'h7f, 32'h37);
      wr(off_cmd_terminal, 32'hfeff);
      chk(assignable, 32'hf800);
      chk(run, 1'b1);
      chk(pulses - p, 1);
      wr(off_cmd_terminal, 32'h010f);
      chk(halt, 1'b1);
      chk(state_word & 16'h7f, 32'h37);
      wr(off_cmd_terminal, 32'h0b);
      chk(qstop, 1'b1);
      chk(state_word & 16'h7f, 32'h11);
      wr(off_cmd_terminal, 32'h0);
      chk(state_word & 16'h7f, 32'h70);
      wr(off_drive_inputs, 32'h05);
      chk(state_word & 16'h0f, 32'h08);
      wr(off_drive_inputs, 32'h01);
      wr(off_cmd_terminal, 32'h80);
      chk(pulses - p, 2);
      chk(state_word & 16'h4f, 32'h40);
   endtask : t_state
   task t_status;
      for (int i = 0; i < 6; i++) begin
         wr(off_drive_inputs, st_in[i]);
         chk(state_word[st_bit[i]], 1'b1);
      end
      wr(off_drive_inputs, 32'h0);
      chk(state_word[sw_voltage], 1'b0);
      for (int c = 0; c < 6; c++) begin
         wr(off_config, c);
         chk(state_word[sw_remote], c >= 2);
      end
   endtask : t_status
   task t_ref;
      wr(off_config, 32'h0);
      wr(off_drive_inputs, 32'h41);
      wr(off_speed_limits, 32'h01f4_0064);
      wr(off_reference, 32'h258);
      chk(state_word[sw_limit], 1'b1);
      wr(off_reference, 32'h12c);
      chk(state_word[sw_limit], 1'b0);
      wr(off_reference, 32'h1b58);
      rd(off_pre_ramp_reference, 32'h1766);
      wr(off_reference, 32'he4a8);
      rd(off_pre_ramp_reference, 32'hffff_e89a);
      wr(off_config, 32'h60);
      rd(off_pre_ramp_reference, 32'h0);
   endtask : t_ref
   task t_two_wire;
      wr(off_config, 32'h100);
      wr(off_cmd_display, 32'h1);
      chk(fwd, 1'b0);
      wr(off_cmd_terminal, 32'h1);
      chk(fwd, 1'b1);
      chk(run, 1'b1);
      wr(off_config, 32'h101);
      wr(off_cmd_display, 32'hffff);
      chk(assignable, 32'hfffe);
      wr(off_cmd_display, 32'h0);
      chk(fwd, 1'b0);
   endtask : t_two_wire
   // edge start, stop by authorisation, no restart without a new edge
   task t_three_wire;
      wr(off_config, 32'h300);
      wr(off_cmd_terminal, 32'h3);
      chk(run, 1'b1);
      wr(off_cmd_terminal, 32'h2);
      chk(run, 1'b0);
      wr(off_cmd_terminal, 32'h3);
      chk(run, 1'b0);
      wr(off_cmd_terminal, 32'h1);
      wr(off_cmd_terminal, 32'h3);
      chk(run, 1'b1);
      wr(off_cmd_display, 32'h0);
      chk(run, 1'b1);
      wr(off_cmd_terminal, 32'hffff);
      chk(assignable, 32'hfffc);
      rd(off_drive_command_word, 32'hffff);
      rd(off_run_status, 32'h7);
      wr(off_config, 32'h2300);
      chk(stop_type, 2'h2);
   endtask : t_three_wire
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      t_reset;
      t_state;
      t_status;
      t_ref;
      t_two_wire;
      t_three_wire;
      end_sim;
   end
   // watchdog well beyond the few hundred cycles the run needs
   initial begin
      #400000;
      mismatches++;
      end_sim;
   end
endmodule : drive_control_status_words_tb_top
